// ===== fdm_mode_ctrl.sv
// Drive mode command block: dictionary objects over APB, mode selection,
// enable sequence, motion triggers and status reporting.
// Assumes a synchronous APB master and plant feedback synchronous to mclk.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module fdm_mode_ctrl
   import fdm_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYC,
   parameter logic [31:0] FREQ_STEP = 32'h00000010,
   parameter logic [15:0] TRQ_STEP = 16'h0004,
   parameter logic [31:0] REACH_TOL = 32'h00000004
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Plant feedback
   input wire logic signed [31:0] act_vel_rpm,
   input wire logic signed [15:0] act_trq,
   input wire logic signed [31:0] act_pos,
   input wire logic home_done,
   // Drive commands
   output logic drv_run,
   output logic signed [31:0] drv_freq,
   output logic drv_ccw,
   output logic signed [15:0] drv_trq,
   output logic signed [31:0] drv_pos,
   output logic drv_move,
   output logic drv_home
);
   typedef struct packed {
      fdm_state_type st;
      logic [7:0] mode;
      logic [15:0] ctrl;
      logic [31:0] tgt_vel;
      logic [15:0] tgt_trq;
      logic [15:0] max_trq;
      logic [31:0] tgt_pos;
      logic [15:0] old_ctrl;
      logic [15:0] old_freq;
      logic [15:0] new_ctrl;
      logic [15:0] new_freq;
      logic [31:0] new_pos;
      logic [15:0] new_trq;
      logic [6:0] node;
      logic [1:0] prof;
      logic [7:0] poles;
      logic [31:0] pos_lim;
      logic [31:0] spd_lim;
      logic home_busy;
      logic [31:0] tick_cnt;
      logic run;
      logic ccw;
      logic [31:0] pos;
      logic move;
      logic home;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } fdm_regs_type;

   fdm_regs_type r_q, r_d;
   logic tick;
   logic wr_en;
   logic signed [31:0] conv_hz;
   logic signed [31:0] freq_tgt;
   logic freq_hold;
   logic signed [15:0] trq_tgt;
   logic signed [15:0] trq_lim;
   logic signed [31:0] frq_q;
   logic signed [15:0] trq_q;
   logic [15:0] stat_word;
   logic [15:0] new_stat;
   logic spd_ok;
   logic trq_ok;
   logic pos_ok;
   logic over_lim;
   logic over_spd;

   function automatic logic [31:0] fdm_abs(input logic signed [31:0] v);
      fdm_abs = v[31] ? 32'(-v) : 32'(v);
   endfunction : fdm_abs

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a[1:0] == 2'h0) && (a <= OFF_SPD_LIM);
   endfunction : is_mapped

   function automatic logic is_ro(input logic [7:0] a);
      is_ro = (a == OFF_STAT) || (a == OFF_ACT_VEL) || (a == OFF_ACT_TRQ) ||
              (a == OFF_ACT_POS) || (a == OFF_NEW_STAT);
   endfunction : is_ro

   fdm_rpm2hz u_conv (
      .rpm(signed'(r_q.tgt_vel)),
      .poles(r_q.poles),
      .centi_hz(conv_hz)
   );

   fdm_ramp #(.W(32)) u_frq (
      .mclk(mclk),
      .resetn(resetn),
      .tick(tick),
      .hold(freq_hold),
      .target(freq_tgt),
      .step(signed'(FREQ_STEP)),
      .value_q(frq_q)
   );

   fdm_ramp #(.W(16)) u_trq (
      .mclk(mclk),
      .resetn(resetn),
      .tick(tick),
      .hold(1'b0),
      .target(trq_tgt),
      .step(signed'(TRQ_STEP)),
      .value_q(trq_q)
   );

   assign tick = (r_q.tick_cnt == 32'(TICK_DIV - 1));
   // Writes take effect only at the edge where the master sees pready.
   assign wr_en = psel && penable && pwrite && r_q.ready && !r_q.err;

   always_comb begin
      // Reference selection per profile and mode.
      freq_tgt = '0;
      freq_hold = 1'b0;
      trq_lim = signed'(r_q.max_trq);
      trq_tgt = '0;
      unique case (r_q.prof)
         PROF_OLD: begin
            if (r_q.old_ctrl == OLD_RUN) begin
               freq_tgt = 32'(signed'({1'b0, r_q.old_freq}));
            end
         end
         PROF_NEW: begin
            if (r_q.mode == MODE_SPD && r_q.new_ctrl == NEW_RUN) begin
               freq_tgt = 32'(signed'({1'b0, r_q.new_freq}));
            end
            if (r_q.mode == MODE_TRQ && r_q.new_ctrl == NEW_ON) begin
               trq_tgt = signed'(r_q.new_trq);
            end
         end
         default: begin
            if (r_q.st == ST_OP && r_q.mode == MODE_SPD) begin
               if (r_q.ctrl[CW_OP_LSB+:3] == OP_RUN) begin
                  freq_tgt = conv_hz;
               end else if (r_q.ctrl[CW_OP_LSB+:3] == OP_HOLD) begin
                  freq_hold = 1'b1;
               end
            end
            if (r_q.st == ST_OP && r_q.mode == MODE_TRQ) begin
               // Operation bits play no part here.
               trq_tgt = signed'(r_q.tgt_trq);
               if (trq_tgt > trq_lim) begin
                  trq_tgt = trq_lim;
               end else if (trq_tgt < -trq_lim) begin
                  trq_tgt = 16'(-trq_lim);
               end
            end
         end
      endcase
      over_spd = fdm_abs(act_vel_rpm) >= r_q.spd_lim;
      if (over_spd) begin
         // Backing off the torque is the only brake available here.
         trq_tgt = '0;
      end
   end

   always_comb begin
      spd_ok = fdm_abs(act_vel_rpm - signed'(r_q.tgt_vel)) <= REACH_TOL;
      trq_ok = fdm_abs(32'(act_trq - trq_tgt)) <= REACH_TOL;
      // The written target object decides, so a pending move clears pos_ok and the statusword reached bit, taken as !pos_ok, reads set.
      pos_ok = fdm_abs(act_pos - signed'(r_q.prof == PROF_NEW ? r_q.new_pos : r_q.tgt_pos)) <= REACH_TOL;
      over_lim = fdm_abs(act_pos) > r_q.pos_lim;
      stat_word = '0;
      stat_word[SW_READY] = !r_q.st[0];
      stat_word[SW_ON] = !r_q.st[0];
      stat_word[SW_OPEN] = r_q.st == ST_OP;
      stat_word[SW_LIMIT] = over_lim;
      stat_word[SW_HOME] = r_q.home_busy;
      if (r_q.mode == MODE_POS) begin
         stat_word[SW_REACHED] = !pos_ok;
      end else if (r_q.mode == MODE_TRQ) begin
         stat_word[SW_REACHED] = trq_ok;
      end else begin
         stat_word[SW_REACHED] = spd_ok;
      end
      new_stat = '0;
      new_stat[0] = (r_q.mode == MODE_POS) ? pos_ok : trq_ok;
   end

   always_comb begin
      r_d = r_q;
      r_d.move = 1'b0;
      r_d.home = 1'b0;
      r_d.tick_cnt = tick ? '0 : r_q.tick_cnt + 32'h00000001;
      // APB: one wait state, answer registered.
      r_d.ready = psel && penable && !r_q.ready;
      r_d.err = 1'b0;
      if (psel && penable && !r_q.ready) begin
         r_d.err = !is_mapped(paddr) || (pwrite && is_ro(paddr)) ||
                   (r_q.node == '0 && paddr != OFF_CFG);
         r_d.rdata = '0;
         if (!pwrite && !r_d.err) begin
            unique case (paddr)
               OFF_MODE: r_d.rdata = 32'(r_q.mode);
               OFF_CTRL: r_d.rdata = 32'(r_q.ctrl);
               OFF_STAT: r_d.rdata = 32'(stat_word);
               OFF_TGT_VEL: r_d.rdata = r_q.tgt_vel;
               OFF_ACT_VEL: r_d.rdata = act_vel_rpm;
               OFF_TGT_TRQ: r_d.rdata = 32'(r_q.tgt_trq);
               OFF_MAX_TRQ: r_d.rdata = 32'(r_q.max_trq);
               OFF_ACT_TRQ: r_d.rdata = 32'(act_trq);
               OFF_TGT_POS: r_d.rdata = r_q.tgt_pos;
               OFF_ACT_POS: r_d.rdata = act_pos;
               OFF_OLD_CTRL: r_d.rdata = 32'(r_q.old_ctrl);
               OFF_OLD_FREQ: r_d.rdata = 32'(r_q.old_freq);
               OFF_NEW_CTRL: r_d.rdata = 32'(r_q.new_ctrl);
               OFF_NEW_FREQ: r_d.rdata = 32'(r_q.new_freq);
               OFF_NEW_POS: r_d.rdata = r_q.new_pos;
               OFF_NEW_TRQ: r_d.rdata = 32'(r_q.new_trq);
               OFF_NEW_STAT: r_d.rdata = 32'(new_stat);
               OFF_CFG: r_d.rdata = {8'h00, r_q.poles, 6'h00, r_q.prof, 1'b0, r_q.node};
               OFF_POS_LIM: r_d.rdata = r_q.pos_lim;
               OFF_SPD_LIM: r_d.rdata = r_q.spd_lim;
               default: r_d.rdata = '0;
            endcase
         end
      end
      if (wr_en) begin
         unique case (paddr)
            OFF_MODE: r_d.mode = pwdata[7:0];
            OFF_CTRL: begin
               r_d.ctrl = pwdata[15:0];
               if (pwdata[3:0] == CW_READY) begin
                  r_d.st = ST_ON;
               end else if (pwdata[3:0] == CW_ENABLE && r_q.st != ST_DIS) begin
                  r_d.st = ST_OP;
               end else begin
                  r_d.st = ST_DIS;
               end
               if (r_q.st == ST_OP && pwdata[3:0] == CW_ENABLE &&
                   pwdata[CW_OP_LSB] && !r_q.ctrl[CW_OP_LSB]) begin
                  if (r_q.mode == MODE_POS) begin
                     r_d.move = 1'b1;
                     r_d.pos = r_q.tgt_pos;
                  end else if (r_q.mode == MODE_HOME) begin
                     r_d.home = 1'b1;
                     r_d.home_busy = 1'b1;
                  end
               end
            end
            OFF_TGT_VEL: r_d.tgt_vel = pwdata;
            OFF_TGT_TRQ: r_d.tgt_trq = pwdata[15:0];
            OFF_MAX_TRQ: r_d.max_trq = pwdata[15:0];
            OFF_TGT_POS: r_d.tgt_pos = pwdata;
            OFF_OLD_CTRL: r_d.old_ctrl = pwdata[15:0];
            OFF_OLD_FREQ: r_d.old_freq = pwdata[15:0];
            OFF_NEW_CTRL: begin
               r_d.new_ctrl = pwdata[15:0];
               if (pwdata[15:0] == NEW_RUN && r_q.new_ctrl == NEW_ON) begin
                  if (r_q.mode == MODE_POS) begin
                     r_d.move = 1'b1;
                     r_d.pos = r_q.new_pos;
                  end else if (r_q.mode == MODE_HOME) begin
                     r_d.home = 1'b1;
                     r_d.home_busy = 1'b1;
                  end
               end
            end
            OFF_NEW_FREQ: r_d.new_freq = pwdata[15:0];
            OFF_NEW_POS: r_d.new_pos = pwdata;
            OFF_NEW_TRQ: r_d.new_trq = pwdata[15:0];
            OFF_CFG: begin
               r_d.node = pwdata[CFG_NODE_LSB+:7];
               r_d.prof = pwdata[CFG_PROF_LSB+:2];
               r_d.poles = pwdata[CFG_POLE_LSB+:8];
            end
            OFF_POS_LIM: r_d.pos_lim = pwdata;
            OFF_SPD_LIM: r_d.spd_lim = pwdata;
            default: r_d.mode = r_q.mode;
         endcase
      end
      // A done level in the same cycle as a start leaves homing busy.
      if (home_done && !r_d.home) begin
         r_d.home_busy = 1'b0;
      end
      if (r_q.node == '0) begin
         r_d.st = ST_DIS;
      end
      unique case (r_q.prof)
         PROF_OLD: r_d.run = r_q.node != '0 && r_q.old_ctrl == OLD_RUN;
         PROF_NEW: r_d.run = r_q.node != '0 && (r_q.new_ctrl == NEW_ON || r_q.new_ctrl == NEW_RUN);
         default: r_d.run = r_q.st == ST_OP;
      endcase
      r_d.ccw = frq_q[31];
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '0;
         r_q.st <= ST_DIS;
         r_q.node <= NODE_RST;
         r_q.prof <= PROF_STD;
         r_q.poles <= POLES_RST;
         r_q.pos_lim <= POS_LIM_RST;
         r_q.spd_lim <= SPD_LIM_RST;
         r_q.old_ctrl <= OLD_STOP;
      end else begin
         r_q <= r_d;
      end
   end

   assign prdata = r_q.rdata;
   assign pready = r_q.ready;
   assign pslverr = r_q.err;
   assign drv_run = r_q.run;
   assign drv_freq = frq_q;
   assign drv_ccw = r_q.ccw;
   assign drv_trq = trq_q;
   assign drv_pos = r_q.pos;
   assign drv_move = r_q.move;
   assign drv_home = r_q.home;

   a_enable_seq: assert property (@(posedge mclk) disable iff (!resetn)
      wr_en && paddr == OFF_CTRL && pwdata[3:0] == CW_ENABLE && r_q.st == ST_ON && r_q.node != '0
      |=> r_q.st == ST_OP)
      else $error("enable sequence did not reach operation enabled");
   a_speed_hold: assert property (@(posedge mclk) disable iff (!resetn)
      r_q.prof == PROF_STD && r_q.st == ST_OP && r_q.mode == MODE_SPD &&
      r_q.ctrl[CW_OP_LSB+:3] == OP_HOLD |=> $stable(drv_freq))
      else $error("held speed reference moved");
   a_reached_bit: assert property (@(posedge mclk) disable iff (!resetn)
      r_q.mode == MODE_SPD && act_vel_rpm == signed'(r_q.tgt_vel) |-> stat_word[SW_REACHED])
      else $error("speed reached bit wrong");
   a_move_start: assert property (@(posedge mclk) disable iff (!resetn)
      wr_en && paddr == OFF_CTRL && r_q.st == ST_OP && r_q.mode == MODE_POS &&
      pwdata[3:0] == CW_ENABLE && pwdata[CW_OP_LSB] && !r_q.ctrl[CW_OP_LSB]
      |=> drv_move && drv_pos == $past(r_q.tgt_pos) ##1 !drv_move)
      else $error("position move not started once");
   a_limit_bit: assert property (@(posedge mclk) disable iff (!resetn)
      (act_pos > signed'(r_q.pos_lim) && !r_q.pos_lim[31]) |-> stat_word[SW_LIMIT])
      else $error("limit bit missing");
   a_home_busy: assert property (@(posedge mclk) disable iff (!resetn)
      drv_home |-> stat_word[SW_HOME])
      else $error("homing not shown busy");
   a_old_run: assert property (@(posedge mclk) disable iff (!resetn)
      wr_en && paddr == OFF_OLD_CTRL && pwdata[15:0] == OLD_RUN && r_q.prof == PROF_OLD
      |=> ##1 drv_run)
      else $error("old definition run not honoured");
   a_node_off: assert property (@(posedge mclk) disable iff (!resetn)
      r_q.node == '0 |=> r_q.st == ST_DIS ##1 !drv_run)
      else $error("slave active with node address zero");
   a_over_speed: assert property (@(posedge mclk) disable iff (!resetn)
      over_spd |=> fdm_abs(32'(drv_trq)) <= fdm_abs(32'($past(drv_trq))))
      else $error("torque not reduced at speed limit");
endmodule : fdm_mode_ctrl
`default_nettype wire

// ===== fdm_pkg.sv
// Constants, register map and types for the drive mode command block.
// Assumes one 250 MHz clock and an APB master on the register side.
package fdm_pkg;
   // Register byte offsets on APB.
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_CTRL = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_TGT_VEL = 8'h0C;
   localparam logic [7:0] OFF_ACT_VEL = 8'h10;
   localparam logic [7:0] OFF_TGT_TRQ = 8'h14;
   localparam logic [7:0] OFF_MAX_TRQ = 8'h18;
   localparam logic [7:0] OFF_ACT_TRQ = 8'h1C;
   localparam logic [7:0] OFF_TGT_POS = 8'h20;
   localparam logic [7:0] OFF_ACT_POS = 8'h24;
   localparam logic [7:0] OFF_OLD_CTRL = 8'h28;
   localparam logic [7:0] OFF_OLD_FREQ = 8'h2C;
   localparam logic [7:0] OFF_NEW_CTRL = 8'h30;
   localparam logic [7:0] OFF_NEW_FREQ = 8'h34;
   localparam logic [7:0] OFF_NEW_POS = 8'h38;
   localparam logic [7:0] OFF_NEW_TRQ = 8'h3C;
   localparam logic [7:0] OFF_NEW_STAT = 8'h40;
   localparam logic [7:0] OFF_CFG = 8'h44;
   localparam logic [7:0] OFF_POS_LIM = 8'h48;
   localparam logic [7:0] OFF_SPD_LIM = 8'h4C;
   // Operating modes and profiles.
   localparam logic [7:0] MODE_POS = 8'h01;
   localparam logic [7:0] MODE_SPD = 8'h02;
   localparam logic [7:0] MODE_TRQ = 8'h04;
   localparam logic [7:0] MODE_HOME = 8'h06;
   localparam logic [1:0] PROF_STD = 2'h0;
   localparam logic [1:0] PROF_OLD = 2'h1;
   localparam logic [1:0] PROF_NEW = 2'h2;
   // Controlword fields and commands.
   localparam logic [3:0] CW_READY = 4'hE;
   localparam logic [3:0] CW_ENABLE = 4'hF;
   localparam int CW_OP_LSB = 4;
   localparam logic [2:0] OP_HOLD = 3'h5;
   localparam logic [2:0] OP_RUN = 3'h7;
   localparam logic [15:0] OLD_RUN = 16'h0002;
   localparam logic [15:0] OLD_STOP = 16'h0001;
   localparam logic [15:0] NEW_ON = 16'h0080;
   localparam logic [15:0] NEW_RUN = 16'h0081;
   // Statusword bit positions.
   localparam int SW_READY = 0;
   localparam int SW_ON = 1;
   localparam int SW_OPEN = 2;
   localparam int SW_REACHED = 10;
   localparam int SW_LIMIT = 11;
   localparam int SW_HOME = 12;
   // Configuration register fields and reset values.
   localparam int CFG_NODE_LSB = 0;
   localparam int CFG_PROF_LSB = 8;
   localparam int CFG_POLE_LSB = 16;
   localparam logic [6:0] NODE_RST = 7'h01;
   localparam logic [7:0] POLES_RST = 8'h04;
   localparam logic [31:0] POS_LIM_RST = 32'h7FFFFFFF;
   localparam logic [31:0] SPD_LIM_RST = 32'h00000BB8;
   // Speed equals frequency times this factor over the pole count.
   localparam int RPM_FACTOR = 120;
   localparam int CENTI = 100;
   // Ramp tick period.
   localparam int CLK_NS = 4;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   typedef enum logic [2:0] {
      ST_DIS = 3'b001,
      ST_ON = 3'b010,
      ST_OP = 3'b100
   } fdm_state_type;
endpackage : fdm_pkg

// ===== fdm_rpm2hz.sv
// Converts a signed speed in rpm into a frequency in 0.01 Hz.
// Assumes a nonzero pole count; zero poles yields zero frequency.
`timescale 1ns/100ps
`default_nettype none
module fdm_rpm2hz
   import fdm_pkg::*;
(
   // Conversion
   input wire logic signed [31:0] rpm,
   input wire logic [7:0] poles,
   output logic signed [31:0] centi_hz
);
   logic signed [47:0] prod;
   always_comb begin
      // The pole count is small, so the product fits easily in 48 bits.
      prod = 48'(rpm) * $signed({40'h0, poles}) * 48'(CENTI);
      centi_hz = 32'(prod / 48'(RPM_FACTOR));
   end
endmodule : fdm_rpm2hz
`default_nettype wire

// ===== fdm_ramp.sv
// Steps a signed value toward a target by a fixed amount per tick.
// Assumes tick is a one-cycle enable from a divider.
`timescale 1ns/100ps
`default_nettype none
module fdm_ramp
   import fdm_pkg::*;
#(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Control
   input wire logic tick,
   input wire logic hold,
   input wire logic signed [W-1:0] target,
   input wire logic signed [W-1:0] step,
   // Result
   output logic signed [W-1:0] value_q
);
   typedef struct packed {
      logic signed [W-1:0] val;
   } fdm_ramp_type;
   fdm_ramp_type r_q, r_d;
   always_comb begin
      r_d = r_q;
      if (tick && !hold) begin
         // Step, but never overshoot, so the target is met exactly.
         if (target - r_q.val > step) begin
            r_d.val = r_q.val + step;
         end else if (r_q.val - target > step) begin
            r_d.val = r_q.val - step;
         end else begin
            r_d.val = target;
         end
      end
   end
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end
   assign value_q = r_q.val;
endmodule : fdm_ramp
`default_nettype wire

// ===== fdm_plant.sv
// Plant stand-in for the drive: torque, position and homing feedback.
// Assumes the block's command outputs and the bench's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module fdm_plant (
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Commands
   input wire logic signed [15:0] drv_trq,
   input wire logic signed [31:0] drv_pos,
   input wire logic drv_move,
   input wire logic drv_home,
   // Feedback
   output logic signed [15:0] act_trq,
   output logic signed [31:0] act_pos,
   output logic home_done
);
   logic [3:0] cnt_q;
   // Homing lasts long enough that the busy flag can be read before it ends.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         act_trq <= '0;
         act_pos <= '0;
         cnt_q <= 4'h0;
      end else begin
         act_trq <= drv_trq;
         if (drv_move) begin
            act_pos <= drv_pos;
         end
         if (drv_home) begin
            cnt_q <= 4'hF;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
   assign home_done = (cnt_q == 4'h1);
endmodule : fdm_plant
`default_nettype wire

// ===== fdm_mode_ctrl_bench.sv
// Self-checking bench for the drive mode command block.
// Assumes the design package and the plant stand-in are compiled first.
`timescale 1ns/100ps
`default_nettype none
module fdm_mode_ctrl_bench;
   import fdm_pkg::*;
   logic mclk, resetn, psel, penable, pwrite, pready, pslverr, er, home_done;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [31:0] act_vel_rpm, act_pos, drv_freq, drv_pos;
   logic signed [15:0] act_trq, drv_trq;
   logic drv_run, drv_ccw, drv_move, drv_home;
   int errors, checked, moves, homes;
   fdm_mode_ctrl #(.TICK_DIV(4)) fdm_mode_ctrl_inst (.mclk(mclk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .act_vel_rpm(act_vel_rpm), .act_trq(act_trq),
      .act_pos(act_pos), .home_done(home_done), .drv_run(drv_run), .drv_freq(drv_freq),
      .drv_ccw(drv_ccw), .drv_trq(drv_trq), .drv_pos(drv_pos), .drv_move(drv_move), .drv_home(drv_home));
   fdm_plant fdm_plant_inst (.mclk(mclk), .resetn(resetn), .drv_trq(drv_trq), .drv_pos(drv_pos),
      .drv_move(drv_move), .drv_home(drv_home), .act_trq(act_trq), .act_pos(act_pos), .home_done(home_done));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (drv_move === 1'b1) moves++;
      if (drv_home === 1'b1) homes++;
   end
   task tally_and_finish;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Two idle edges after each transfer let one-cycle pulses reach the counters first.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the answer.
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(er, 1'b0);
   endtask : wr
   task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask : rdm
   task wv(input bit s, input logic [31:0] e);
      logic [31:0] v;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         v = s ? 32'(drv_trq) : drv_freq;
         n++;
      end while (v !== e && n < 4000);
      chk(v, e);
   endtask : wv
   task en(input logic [7:0] m);
      wr(OFF_MODE, 32'(m));
      wr(OFF_CTRL, 32'hE);
      wr(OFF_CTRL, 32'hF);
      rdm(OFF_STAT, 32'h4, 32'h4);
   endtask : en
   task t_reset;
      rdm(OFF_CFG, '1, 32'h00040001);
      rdm(OFF_POS_LIM, '1, POS_LIM_RST);
      rdm(OFF_SPD_LIM, '1, SPD_LIM_RST);
      rdm(OFF_OLD_CTRL, '1, 32'h1);
      apb(1'b0, 8'h50, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, OFF_STAT, 32'h0);
      chk(er, 1'b1);
   endtask : t_reset
   task t_speed;
      en(MODE_SPD);
      wr(OFF_TGT_VEL, 32'd1500);
      wr(OFF_CTRL, 32'h7F);
      wv(1'b0, 32'd5000);
      chk(drv_run, 1'b1);
      act_vel_rpm <= 32'd1500;
      rdm(OFF_ACT_VEL, '1, 32'd1500);
      rdm(OFF_STAT, 32'h400, 32'h400);
      // Hold first, so the new target cannot start the ramp before it is frozen.
      wr(OFF_CTRL, 32'h5F);
      wr(OFF_TGT_VEL, 32'd300);
      repeat (40) @(posedge mclk);
      chk(drv_freq, 32'd5000);
      rdm(OFF_STAT, 32'h400, 32'h0);
      wr(OFF_CTRL, 32'h0F);
      wv(1'b0, 32'h0);
      wr(OFF_TGT_VEL, -32'sd120);
      wr(OFF_CTRL, 32'h7F);
      wv(1'b0, -32'sd400);
      @(posedge mclk);
      chk(drv_ccw, 1'b1);
      chk(moves, 0);
   endtask : t_speed
   task t_torque;
      act_vel_rpm <= 32'h0;
      en(MODE_TRQ);
      wr(OFF_TGT_TRQ, 32'd200);
      wr(OFF_MAX_TRQ, 32'd150);
      wr(OFF_CTRL, 32'h0F);
      wv(1'b1, 32'd150);
      rdm(OFF_ACT_TRQ, '1, 32'd150);
      rdm(OFF_STAT, 32'h400, 32'h400);
      act_vel_rpm <= 32'd3000;
      wv(1'b1, 32'h0);
      act_vel_rpm <= 32'h0;
   endtask : t_torque
   task t_pos;
      en(MODE_POS);
      wr(OFF_TGT_POS, 32'd1234);
      wr(OFF_CTRL, 32'h0F);
      rdm(OFF_STAT, 32'h400, 32'h400);
      wr(OFF_CTRL, 32'h1F);
      chk(moves, 1);
      chk(drv_pos, 32'd1234);
      rdm(OFF_ACT_POS, '1, 32'd1234);
      rdm(OFF_STAT, 32'hC00, 32'h0);
      wr(OFF_POS_LIM, 32'd1000);
      rdm(OFF_STAT, 32'h800, 32'h800);
      wr(OFF_POS_LIM, POS_LIM_RST);
   endtask : t_pos
   task t_home;
      en(MODE_HOME);
      wr(OFF_CTRL, 32'h0F);
      wr(OFF_CTRL, 32'h1F);
      chk(homes, 1);
      rdm(OFF_STAT, 32'h1000, 32'h1000);
      repeat (20) @(posedge mclk);
      rdm(OFF_STAT, 32'h1000, 32'h0);
   endtask : t_home
   task t_old;
      wr(OFF_CFG, 32'h00040101);
      wr(OFF_MODE, 32'(MODE_SPD));
      wr(OFF_OLD_FREQ, 32'd1000);
      wr(OFF_OLD_CTRL, 32'(OLD_RUN));
      wv(1'b0, 32'd1000);
      wr(OFF_OLD_CTRL, 32'(OLD_STOP));
      wv(1'b0, 32'h0);
   endtask : t_old
   task t_new;
      wr(OFF_CFG, 32'h00040201);
      wr(OFF_MODE, 32'(MODE_SPD));
      wr(OFF_NEW_CTRL, 32'(NEW_ON));
      wr(OFF_NEW_FREQ, 32'd500);
      wr(OFF_NEW_CTRL, 32'(NEW_RUN));
      wv(1'b0, 32'd500);
      wr(OFF_MODE, 32'(MODE_TRQ));
      wr(OFF_NEW_TRQ, 32'd50);
      wr(OFF_NEW_CTRL, 32'(NEW_ON));
      wv(1'b1, 32'd50);
      rdm(OFF_NEW_STAT, 32'h1, 32'h1);
      wr(OFF_MODE, 32'(MODE_POS));
      wr(OFF_NEW_CTRL, 32'(NEW_ON));
      wr(OFF_NEW_POS, 32'd77);
      wr(OFF_NEW_CTRL, 32'(NEW_RUN));
      chk(moves, 2);
      chk(drv_pos, 32'd77);
      rdm(OFF_NEW_STAT, 32'h1, 32'h1);
   endtask : t_new
   task t_node;
      wr(OFF_CFG, 32'h00040000);
      apb(1'b0, OFF_MODE, 32'h0);
      chk(er, 1'b1);
      chk(drv_run, 1'b0);
      wr(OFF_CFG, 32'h00040001);
      rdm(OFF_CFG, '1, 32'h00040001);
   endtask : t_node
   // The normal run is under ten thousand cycles; this bound allows every wait to expire.
   initial begin
      #400000;
      errors++;
      tally_and_finish;
   end
   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      act_vel_rpm = 32'h0;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      t_reset;
      t_speed;
      t_torque;
      t_pos;
      t_home;
      t_old;
      t_new;
      t_node;
      tally_and_finish;
   end
endmodule : fdm_mode_ctrl_bench
`default_nettype wire
